// ===== design/evg_event_generator.sv
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "evg_regs.svh"
module evg_event_generator #(
	parameter int NUM_TASKS = 16,
	parameter int NUM_CHANNELS = 256
)
(
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [11:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic wb_err_o,
	input wire logic [NUM_CHANNELS-1:0] chan_event_i,
	output logic [NUM_CHANNELS-1:0] chan_publish_o,
	output logic irq_o
);

	logic [31:0] subscribe_reg [NUM_TASKS];
	logic [31:0] publish_reg [NUM_TASKS];
	logic [NUM_TASKS-1:0] event_reg;
	logic [NUM_TASKS-1:0] event_next;
	logic [NUM_TASKS-1:0] interrupt_enable_mask_reg;
	logic [NUM_TASKS-1:0] trigger;
	logic [NUM_TASKS-1:0] sw_trigger;
	logic [NUM_TASKS-1:0] hw_trigger;
	logic [NUM_CHANNELS-1:0] publish_next;
	logic [31:0] rdata_next;
	logic [31:0] wmask;
	logic req;
	logic wr;
	evg_pkg::evg_area_type area;
	logic [3:0] idx;
	logic idx_ok;
	logic mapped;
	logic ev_clr;
	logic ev_set;
	logic [NUM_TASKS-1:0] wr_bits;
	// The enable mask widened to a full bus word, so a partial write
	// through the byte lanes can be merged before it is narrowed again.
	logic [31:0] interrupt_enable_mask_merged;

	// Decodes a word address to its register area; the array index is taken from idx.
	function automatic evg_pkg::evg_area_type decode_area(
		input logic [11:0] adr
	);
		logic [11:0] base;
		base = {adr[11:7], 7'h00};
		if (adr[1:0] != 2'h0)
			decode_area = evg_pkg::EVG_AREA_NONE;
		else if (base == `EVG_TRIGGER_BASE)
			decode_area = evg_pkg::EVG_AREA_TRIGGER;
		else if (base == `EVG_SUBSCRIBE_BASE)
			decode_area = evg_pkg::EVG_AREA_SUBSCRIBE;
		else if (base == `EVG_EVENT_BASE)
			decode_area = evg_pkg::EVG_AREA_EVENT;
		else if (base == `EVG_PUBLISH_BASE)
			decode_area = evg_pkg::EVG_AREA_PUBLISH;
		else if (adr == `EVG_INTERRUPT_ENABLE_MASK_OFF)
			decode_area = evg_pkg::EVG_AREA_INTERRUPT_ENABLE_MASK;
		else if (adr == `EVG_INTERRUPT_ENABLE_SET_OFF)
			decode_area = evg_pkg::EVG_AREA_INTERRUPT_ENABLE_SET;
		else if (adr == `EVG_INTERRUPT_ENABLE_CLEAR_OFF)
			decode_area = evg_pkg::EVG_AREA_INTERRUPT_ENABLE_CLEAR;
		else
			decode_area = evg_pkg::EVG_AREA_NONE;
	endfunction

	// Applies byte enables so a partial write keeps unselected lanes.
	function automatic logic [31:0] merge(
		input logic [31:0] old,
		input logic [31:0] data,
		input logic [31:0] mask
	);
		merge = (old & ~mask) | (data & mask);
	endfunction

	// Channel number held in a subscribe or publish register.
	function automatic logic [`EVG_CHAN_W-1:0] cfg_chan(
		input logic [31:0] cfg
	);
		cfg_chan = cfg[`EVG_CHAN_LSB +: `EVG_CHAN_W];
	endfunction

	// A link is live only while its enable bit is set, so software can
	// park a channel number in the register without it taking effect.
	function automatic logic cfg_on(
		input logic [31:0] cfg
	);
		cfg_on = cfg[`EVG_CFG_EN_BIT];
	endfunction

	// Array areas need an index below the task count; the enable
	// registers stand alone and are always mapped.
	function automatic logic is_mapped(
		input evg_pkg::evg_area_type a,
		input logic ok
	);
		if (a == evg_pkg::EVG_AREA_NONE)
			is_mapped = 1'b0;
		else if (a <= evg_pkg::EVG_AREA_PUBLISH)
			is_mapped = ok;
		else
			is_mapped = 1'b1;
	endfunction

	assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
	assign area = decode_area(wb_adr_i);
	assign idx = wb_adr_i[5:2];
	assign idx_ok = (int'(idx) < NUM_TASKS) & ~wb_adr_i[6];
	assign wr = req & wb_we_i;
	assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
		{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign mapped = is_mapped(area, idx_ok);

	// Flag writes only look at bit 0 of lane 0; the other bits of the
	// word carry nothing, so a wide store cannot disturb a neighbour.
	assign ev_clr = wr && area == evg_pkg::EVG_AREA_EVENT && idx_ok
		&& wb_sel_i[0] && !wb_dat_i[0];
	assign ev_set = wr && area == evg_pkg::EVG_AREA_EVENT && idx_ok
		&& wb_sel_i[0] && wb_dat_i[0];

	// Bits that a set or clear write touches; unselected lanes are zero
	// so they leave their enables alone.
	assign wr_bits = wb_dat_i[NUM_TASKS-1:0] & wmask[NUM_TASKS-1:0];
	assign interrupt_enable_mask_merged = merge(32'(interrupt_enable_mask_reg), wb_dat_i, wmask);

	// Software triggers: a write of one in bit 0 fires the task.
	always_comb
	begin
		sw_trigger = '0;
		if (wr && area == evg_pkg::EVG_AREA_TRIGGER && idx_ok
			&& wb_sel_i[0] && wb_dat_i[0])
			sw_trigger[idx] = 1'b1;
	end

	// Channel triggers use the subscription's channel and enable bit.
	always_comb
	begin
		hw_trigger = '0;
		for (int n = 0; n < NUM_TASKS; n++)
		begin
			if (cfg_on(subscribe_reg[n]))
				hw_trigger[n] =
					chan_event_i[cfg_chan(subscribe_reg[n])];
		end
	end

	assign trigger = sw_trigger | hw_trigger;

	// A trigger in the same cycle as a clearing write wins, so no event
	// is lost to a racing acknowledge.
	always_comb
	begin
		event_next = event_reg;
		if (ev_clr)
			event_next[idx] = 1'b0;
		else if (ev_set)
			event_next[idx] = 1'b1;
		event_next = event_next | trigger;
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			event_reg <= '0;
		end
		else
		begin
			event_reg <= event_next;
		end
	end

	// Publishing fires on the trigger itself, one cycle pulse per event.
	always_comb
	begin
		publish_next = '0;
		for (int n = 0; n < NUM_TASKS; n++)
		begin
			if (trigger[n] && cfg_on(publish_reg[n]))
				publish_next[cfg_chan(publish_reg[n])] = 1'b1;
		end
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			chan_publish_o <= '0;
		end
		else
		begin
			// Two tasks that publish on one channel in the same cycle
			// merge into a single pulse; the channel cannot count them.
			chan_publish_o <= publish_next;
		end
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			for (int n = 0; n < NUM_TASKS; n++)
			begin
				subscribe_reg[n] <= `EVG_CFG_RESET;
				publish_reg[n] <= `EVG_CFG_RESET;
			end
		end
		else if (wr && idx_ok)
		begin
			if (area == evg_pkg::EVG_AREA_SUBSCRIBE)
				subscribe_reg[idx] <= merge(subscribe_reg[idx], wb_dat_i,
					wmask);
			if (area == evg_pkg::EVG_AREA_PUBLISH)
				publish_reg[idx] <= merge(publish_reg[idx], wb_dat_i,
					wmask);
		end
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			interrupt_enable_mask_reg <= `EVG_INTERRUPT_ENABLE_MASK_RESET;
		else if (wr)
		begin
			case (area)
				evg_pkg::EVG_AREA_INTERRUPT_ENABLE_MASK:
					interrupt_enable_mask_reg <= interrupt_enable_mask_merged[NUM_TASKS-1:0];
				// Set and clear words let one interrupt handler change its
				// own enables without a read-modify-write race.
				evg_pkg::EVG_AREA_INTERRUPT_ENABLE_SET:
					interrupt_enable_mask_reg <= interrupt_enable_mask_reg | wr_bits;
				evg_pkg::EVG_AREA_INTERRUPT_ENABLE_CLEAR:
					interrupt_enable_mask_reg <= interrupt_enable_mask_reg & ~wr_bits;
				default:
					interrupt_enable_mask_reg <= interrupt_enable_mask_reg;
			endcase
		end
	end

	// The request is registered from the next flag value, so it rises on the same edge as the flag.
	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			irq_o <= 1'b0;
		end
		else
		begin
			// A newly written enable only counts from the next edge, so
			// enabling an already set flag takes one extra cycle.
			irq_o <= |(event_next & interrupt_enable_mask_reg);
		end
	end

	always_comb
	begin
		rdata_next = 32'h00000000;
		case (area)
			evg_pkg::EVG_AREA_SUBSCRIBE:
				rdata_next = subscribe_reg[idx];
			evg_pkg::EVG_AREA_EVENT:
				rdata_next = {31'h00000000, event_reg[idx]};
			evg_pkg::EVG_AREA_PUBLISH:
				rdata_next = publish_reg[idx];
			evg_pkg::EVG_AREA_INTERRUPT_ENABLE_MASK,
			evg_pkg::EVG_AREA_INTERRUPT_ENABLE_SET,
			evg_pkg::EVG_AREA_INTERRUPT_ENABLE_CLEAR:
				rdata_next = {16'h0000, interrupt_enable_mask_reg};
			default:
				rdata_next = 32'h00000000;
		endcase
		// Words beyond the task count read as zero, matching the error.
		if (!mapped)
			rdata_next = 32'h00000000;
	end

	// Unmapped addresses get an error rather than a silent ack, so a
	// wrong base address shows up at once in software.
	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			wb_ack_o <= 1'b0;
			wb_err_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end
		else
		begin
			wb_ack_o <= req && mapped;
			wb_err_o <= req && !mapped;
			// Data stays zero outside an answer, so a bus that ORs its
			// slaves' read data needs no extra gating here.
			wb_dat_o <= req ? rdata_next : 32'h00000000;
		end
	end

endmodule

// ===== design/evg_regs.svh
`ifndef EVG_REGS_SVH
`define EVG_REGS_SVH

`define EVG_TRIGGER_BASE 12'h000
`define EVG_SUBSCRIBE_BASE 12'h080
`define EVG_EVENT_BASE 12'h100
`define EVG_PUBLISH_BASE 12'h180
`define EVG_INTERRUPT_ENABLE_MASK_OFF 12'h300
`define EVG_INTERRUPT_ENABLE_SET_OFF 12'h304
`define EVG_INTERRUPT_ENABLE_CLEAR_OFF 12'h308
`define EVG_ARRAY_STRIDE 12'h004
`define EVG_CHAN_LSB 0
`define EVG_CHAN_W 8
`define EVG_CFG_EN_BIT 31
`define EVG_CFG_RESET 32'h00000000
`define EVG_INTERRUPT_ENABLE_MASK_RESET 16'h0000
`define EVG_IRQ_LATENCY_CYC 1

`endif

// ===== design/evg_pkg.sv
package evg_pkg;
	typedef enum logic [2:0]
	{
		EVG_AREA_TRIGGER = 3'h0,
		EVG_AREA_SUBSCRIBE = 3'h1,
		EVG_AREA_EVENT = 3'h2,
		EVG_AREA_PUBLISH = 3'h3,
		EVG_AREA_INTERRUPT_ENABLE_MASK = 3'h4,
		EVG_AREA_INTERRUPT_ENABLE_SET = 3'h5,
		EVG_AREA_INTERRUPT_ENABLE_CLEAR = 3'h6,
		EVG_AREA_NONE = 3'h7
	} evg_area_type;
endpackage

// ===== sim/evg_monitor.sv
`timescale 1ns/1ps
module evg_monitor #(
	parameter int NUM_CHANNELS = 256
)
(
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [11:0] wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic wb_err_o,
	input wire logic [NUM_CHANNELS-1:0] chan_event_i,
	input wire logic irq_o
);
	default clocking @(posedge sys_clk_i);
	endclocking
	default disable iff (!nrst_i);
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	endsequence
	a_ack_follows: assert property (s_req |=> wb_ack_o != wb_err_o)
		else $error("request not answered once");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held");
	a_idle_quiet: assert property (!wb_stb_i |=> !wb_ack_o && !wb_err_o)
		else $error("answer without request");
	a_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data outside ack");
	a_misalign_err: assert property (s_req ##0 wb_adr_i[1:0] != 2'h0 |=> wb_err_o)
		else $error("misaligned access accepted");
	a_trig_reads0: assert property (s_req ##0 !wb_we_i && wb_adr_i < 12'h040
		|=> wb_dat_o == 32'h0)
		else $error("trigger read nonzero");
	a_irq_cause: assert property ($rose(irq_o)
		|-> $past(wb_stb_i && wb_we_i || |chan_event_i))
		else $error("irq rose without cause");
	a_irq_holds: assert property (irq_o && !(wb_stb_i && wb_we_i) |=> irq_o)
		else $error("irq dropped without clear");
endmodule

// ===== sim/evg_chan_model.sv
`timescale 1ns/1ps
module evg_chan_model
(
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic fire_i,
	input wire logic [7:0] ch_i,
	output logic [255:0] chan_event_o
);
	// Channels follow fire_i one clock late, so a one-cycle fire_i gives a one-cycle pulse and a held fire_i a held level.
	always_ff @(posedge clk_i or negedge nrst_i)
		if (!nrst_i)
			chan_event_o <= 256'h0;
		else
			chan_event_o <= fire_i ? 256'h1 << ch_i : 256'h0;
endmodule

// ===== sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	logic sys_clk_i = 1'b0, nrst_i = 1'b0, fire = 1'b0, seen = 1'b0;
	logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, ge;
	logic [11:0] wb_adr_i = 12'h000;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd, r;
	logic [3:0] wb_sel_i = 4'hF;
	logic [7:0] ch = 8'h00, pch = 8'h00;
	logic [255:0] chan_event_i, chan_publish_o;
	logic wb_ack_o, wb_err_o, irq_o;
	int mismatches = 0, checks_done = 0, n, k;
	always #12.5 sys_clk_i = ~sys_clk_i;
	always @(posedge sys_clk_i)
		if (fire)
			seen <= 1'b0;
		else if (chan_publish_o[pch])
			seen <= 1'b1;
	evg_event_generator uut (.*);
	evg_chan_model pm (.clk_i(sys_clk_i), .nrst_i(nrst_i), .fire_i(fire),
		.ch_i(ch), .chan_event_o(chan_event_i));
	task automatic chk(string s, logic [31:0] e, logic [31:0] g);
		checks_done++;
		if (g !== e)
		begin
			mismatches++;
			$display("BAD %s exp %h got %h", s, e, g);
		end
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic wb(logic w, logic [11:0] a, logic [31:0] d);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		k = 0;
		do
		begin
			@(posedge sys_clk_i);
			k++;
		end
		while (!(wb_ack_o || wb_err_o) && k < 50);
		if (!(wb_ack_o || wb_err_o))
		begin
			mismatches++;
			close_out();
		end
		rd = wb_dat_o;
		ge = wb_err_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge sys_clk_i);
	endtask
	initial
	begin
		n = $urandom(32'hAC29D700);
		repeat (10) @(posedge sys_clk_i);
		nrst_i <= 1'b1;
		@(posedge sys_clk_i);
		wb(0, 12'h300, 0);
		chk("interrupt_enable_mask", 0, rd);
		wb(1, 12'h304, 32'h0000FFFF);
		wb(1, 12'h308, 32'h00000005);
		wb(0, 12'h300, 0);
		chk("interrupt_enable_mask", 32'h0000FFFA, rd);
		wb(1, 12'h300, 32'h0000FFFF);
		for (n = 0; n < 16; n++)
		begin
			wb(1, 12'(4 * n), 32'h0);
			wb(1, 12'(4 * n), 32'h1);
			chk("irq", 1, irq_o);
			for (int m = 0; m < 16; m++)
			begin
				wb(0, 12'h100 + 12'(4 * m), 0);
				chk("flag", 32'(m == n), rd);
			end
			wb(0, 12'(4 * n), 0);
			chk("trig", 0, rd);
			wb(1, 12'h100 + 12'(4 * n), 0);
			chk("irq", 0, irq_o);
		end
		wb(1, 12'h308, 32'h0000FFFF);
		wb(1, 12'h008, 32'h1);
		chk("irq", 0, irq_o);
		wb(1, 12'h304, 32'h00000004);
		chk("irq", 1, irq_o);
		wb(1, 12'h108, 0);
		repeat (4)
		begin
			n = $urandom % 16;
			r = $urandom;
			ch <= r[7:0];
			pch <= r[15:8];
			wb(1, 12'h080 + 12'(4 * n), {1'b1, 23'h0, r[7:0]});
			wb(1, 12'h180 + 12'(4 * n), {1'b1, 23'h0, r[15:8]});
			fire <= 1'b1;
			@(posedge sys_clk_i);
			fire <= 1'b0;
			repeat (3) @(posedge sys_clk_i);
			chk("pub", 1, seen);
			wb(0, 12'h100 + 12'(4 * n), 0);
			chk("flag", 1, rd);
			wb(1, 12'h100 + 12'(4 * n), 0);
			wb(1, 12'h080 + 12'(4 * n), 0);
		end
		wb(0, 12'h400, 0);
		chk("err", 1, ge);
		wb(1, 12'h102, 1);
		chk("err", 1, ge);
		close_out();
	end
endmodule
bind evg_event_generator evg_monitor #(.NUM_CHANNELS(NUM_CHANNELS)) mon (.*);
